// file: design/eam_generator.sv
// How it works
// - file operand uses 13-bit field, near only
// - absolute move reaches whole data space
// - first source register direct; second register/5-bit literal
// - post-modify: use pointer, then add constant
// - pre-modify: add signed constant, then use
// - register offset: pointer plus offset register
// - literal offset: pointer plus literal
// - move class also allows indexed mode
// - move source/destination modes independent, shared offset
// - prefetch 8,9 to X; 10,11 to Y
// - prefetch modes: indirect, post 2/4/6, indexed
// - branch 16-bit signed, disable 14-bit unsigned literal
// - one circular buffer per X and Y
// - power-of-two buffers checked both boundaries
// - 16-bit start and end registers each
// - Y wrapped addresses keep bit 0 clear
// - length from end minus start, 32K max
// - X wrap: select bits 3:0, enable 15
// - Y wrap: select bits 7:4, enable 14
// - boundary passed, not only equal, triggers wrap
// - corrected value written back only pre/post
// - bit-reverse disables X write wrap only
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module eam_generator #(
  parameter int NUM_REGS = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // bit-reverse active in the write generator (owned elsewhere)
  input wire logic bitRevActive,
  // decoder request: read-side (X read / Y) and write-side operands
  input wire logic opValid,
  input wire logic [15:0] instrWord,
  input wire logic [2:0] srcMode,
  input wire logic [3:0] srcPtr,
  input wire logic [2:0] dstMode,
  input wire logic [3:0] dstPtr,
  input wire logic [3:0] ofsReg,
  input wire logic [15:0] litOffset,
  input wire logic signed [15:0] modStep,
  input wire logic srcYSpace,
  // dual-operand prefetch
  input wire logic pfValid,
  input wire logic pfXSel,
  input wire logic pfYSel,
  input wire logic [1:0] pfXMode,
  input wire logic [1:0] pfYMode,
  input wire logic [1:0] pfXStep,
  input wire logic [1:0] pfYStep,
  // working registers as seen by the generator
  input wire logic [15:0] wregs [NUM_REGS],
  // outputs
  output logic [15:0] srcAddr,
  output logic [15:0] dstAddr,
  output logic [15:0] pfXAddr,
  output logic [15:0] pfYAddr,
  output logic [15:0] shortLit,
  output logic [15:0] branchLit,
  output logic [15:0] disableLit,
  output logic addrValid,
  output logic wbValid,
  output logic [3:0] wbReg,
  output logic [15:0] wbData,
  output logic wb2Valid,
  output logic [3:0] wb2Reg,
  output logic [15:0] wb2Data
);
  // refused at elaboration: the pointer fields are 4 bits and always reach 16 registers
  if (NUM_REGS != 16) begin : g_bad_regs
    $error("eam_generator: NUM_REGS must be 16");
  end

  logic [15:0] modeCtrl_r, xStart_r, xEnd_r, yStart_r, yEnd_r;
  logic [1:0] wrapSeen_r;
  logic [15:0] rdNxt;
  logic xWrapOn, yWrapOn;
  logic [3:0] xSel, ySel;

  // control registers; X start/end are full 16 bits, Y start/end force bit 0 to 0 and 1
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      modeCtrl_r <= eam_pkg::EAM_MODE_CTRL_RST;
      xStart_r <= eam_pkg::EAM_ADDR_RST;
      xEnd_r <= eam_pkg::EAM_ADDR_RST;
      yStart_r <= eam_pkg::EAM_ADDR_RST;
      yEnd_r <= eam_pkg::EAM_ADDR_RST;
    end else if (regWr) begin
      case (regAddr)
        eam_pkg::EAM_OFS_MODE_CTRL: modeCtrl_r <= regWdata;
        eam_pkg::EAM_OFS_X_START: xStart_r <= regWdata;
        eam_pkg::EAM_OFS_X_END: xEnd_r <= regWdata;
        eam_pkg::EAM_OFS_Y_START: yStart_r <= {regWdata[15:1], 1'b0};
        eam_pkg::EAM_OFS_Y_END: yEnd_r <= {regWdata[15:1], 1'b1};
        default: ;
      endcase
    end
  end

  // read mux; status shows the latest wrap events
  always_comb begin
    case (regAddr)
      eam_pkg::EAM_OFS_MODE_CTRL: rdNxt = modeCtrl_r;
      eam_pkg::EAM_OFS_X_START: rdNxt = xStart_r;
      eam_pkg::EAM_OFS_X_END: rdNxt = xEnd_r;
      eam_pkg::EAM_OFS_Y_START: rdNxt = yStart_r;
      eam_pkg::EAM_OFS_Y_END: rdNxt = yEnd_r;
      eam_pkg::EAM_OFS_STATUS: rdNxt = {14'h0000, wrapSeen_r};
      default: rdNxt = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) regRdata <= 16'h0000;
    else if (regRd) regRdata <= rdNxt;
    else regRdata <= 16'h0000;
  end

  // one X buffer and one Y buffer, each with its own select/enable
  assign xSel = modeCtrl_r[eam_pkg::EAM_XSEL_LSB +: 4];
  assign ySel = modeCtrl_r[eam_pkg::EAM_YSEL_LSB +: 4];
  assign xWrapOn = modeCtrl_r[eam_pkg::EAM_XEN_BIT] && (xSel != eam_pkg::EAM_SEL_OFF);
  assign yWrapOn = modeCtrl_r[eam_pkg::EAM_YEN_BIT] && (ySel != eam_pkg::EAM_SEL_OFF);

  // wrap correction: compares use < and >, so jumps past a boundary still wrap;
  // both boundaries checked so power-of-two buffers run either way
  // length = end - start + 1, implied, up to 32K words
  function automatic logic [16:0] wrapFix(input logic [15:0] a, input logic [15:0] s,
                                          input logic [15:0] e);
    logic [15:0] len;
    len = 16'(e - s + 16'h0001);
    if (a > e) wrapFix = {1'b1, 16'(a - len)};
    else if (a < s) wrapFix = {1'b1, 16'(a + len)};
    else wrapFix = {1'b0, a};
  endfunction : wrapFix

  // applies wrap to one generated address for a pointer in a given space
  function automatic logic [16:0] spaceFix(input logic [15:0] a, input logic [3:0] ptr,
                                           input logic ySpace, input logic xAllowed,
                                           input logic [15:0] xs, input logic [15:0] xe,
                                           input logic [15:0] ys, input logic [15:0] ye,
                                           input logic xo, input logic yo,
                                           input logic [3:0] xw, input logic [3:0] yw);
    logic [16:0] r;
    r = {1'b0, a};
    if (ySpace) begin
      if (yo && ptr == yw) r = wrapFix(a, ys, ye);
      r[0] = 1'b0;
    end else if (xAllowed && xo && ptr == xw) begin
      r = wrapFix(a, xs, xe);
    end
    spaceFix = r;
  endfunction : spaceFix

  // address of one operand; returns {writeBack, newPtr, ea}
  logic [15:0] sPtrV, dPtrV, sOfsV;
  logic [15:0] sRaw, sMod, dRaw, dMod;
  logic sWb, dWb;
  logic [16:0] sFix, dFix, sModFix, dModFix;
  logic [15:0] fileAddr;

  assign sPtrV = wregs[srcPtr];
  assign dPtrV = wregs[dstPtr];
  assign sOfsV = wregs[ofsReg]; // one offset field shared by both operands
  // zero-extended 13-bit field keeps file operands in the near region
  assign fileAddr = {3'b000, instrWord[eam_pkg::EAM_FILE_W-1:0]};

  // raw effective address and modified pointer per mode
  function automatic logic [32:0] rawEa(input logic [2:0] m, input logic [15:0] p,
                                        input logic [15:0] ofs, input logic [15:0] lit,
                                        input logic [15:0] step, input logic [15:0] fa);
    logic [15:0] ea, np;
    logic wb;
    ea = p;
    np = p;
    wb = 1'b0;
    case (m)
      eam_pkg::EAM_DIRECT: ea = p; // register direct, no memory access
      eam_pkg::EAM_IND: ea = p;
      eam_pkg::EAM_POST: begin
        ea = p;
        np = 16'(p + step);
        wb = 1'b1;
      end
      eam_pkg::EAM_PRE: begin
        np = 16'(p + step);
        ea = np;
        wb = 1'b1;
      end
      eam_pkg::EAM_REGOFS: ea = 16'(p + ofs);
      eam_pkg::EAM_LITOFS: ea = 16'(p + lit);
      eam_pkg::EAM_FILE: ea = fa;
      eam_pkg::EAM_ABS: ea = lit; // full 16-bit data space for moves
      default: ea = p;
    endcase
    rawEa = {wb, np, ea};
  endfunction : rawEa

  logic [32:0] sR, dR;
  assign sR = rawEa(srcMode, sPtrV, sOfsV, litOffset, modStep, fileAddr);
  assign dR = rawEa(dstMode, dPtrV, sOfsV, litOffset, modStep, fileAddr);
  assign sRaw = sR[15:0];
  assign sMod = sR[31:16];
  assign sWb = sR[32];
  assign dRaw = dR[15:0];
  assign dMod = dR[31:16];
  assign dWb = dR[32];

  // read side may always wrap in X; write side yields to bit-reverse
  assign sFix = spaceFix(sRaw, srcPtr, srcYSpace, 1'b1, xStart_r, xEnd_r, yStart_r, yEnd_r,
                         xWrapOn, yWrapOn, xSel, ySel);
  assign sModFix = spaceFix(sMod, srcPtr, srcYSpace, 1'b1, xStart_r, xEnd_r, yStart_r,
                            yEnd_r, xWrapOn, yWrapOn, xSel, ySel);
  assign dFix = spaceFix(dRaw, dstPtr, 1'b0, !bitRevActive, xStart_r, xEnd_r, yStart_r,
                         yEnd_r, xWrapOn, yWrapOn, xSel, ySel);
  assign dModFix = spaceFix(dMod, dstPtr, 1'b0, !bitRevActive, xStart_r, xEnd_r, yStart_r,
                            yEnd_r, xWrapOn, yWrapOn, xSel, ySel);

  // prefetch: fixed register pairs and steps 2/4/6
  logic [3:0] pxReg, pyReg;
  logic [15:0] pxPtr, pyPtr, pxStep, pyStep, pxEa, pyEa, pxNew, pyNew;
  logic [16:0] pxFix, pyFix, pxNewFix, pyNewFix;
  assign pxReg = pfXSel ? eam_pkg::EAM_PF_X1 : eam_pkg::EAM_PF_X0;
  assign pyReg = pfYSel ? eam_pkg::EAM_PF_Y1 : eam_pkg::EAM_PF_Y0;
  assign pxPtr = wregs[pxReg];
  assign pyPtr = wregs[pyReg];
  assign pxStep = {13'h0000, pfXStep, 1'b0}; // 0,2,4,6
  assign pyStep = {13'h0000, pfYStep, 1'b0};
  // mode 0 indirect, 1 post-modified, 2 indexed (second register of each pair only)
  assign pxEa = (pfXMode == 2'h2 && pfXSel) ? 16'(pxPtr + wregs[4'hC]) : pxPtr;
  assign pyEa = (pfYMode == 2'h2 && pfYSel) ? 16'(pyPtr + wregs[4'hC]) : pyPtr;
  assign pxNew = 16'(pxPtr + pxStep);
  assign pyNew = 16'(pyPtr + pyStep);
  assign pxFix = spaceFix(pxEa, pxReg, 1'b0, 1'b1, xStart_r, xEnd_r, yStart_r, yEnd_r,
                          xWrapOn, yWrapOn, xSel, ySel);
  assign pyFix = spaceFix(pyEa, pyReg, 1'b1, 1'b1, xStart_r, xEnd_r, yStart_r, yEnd_r,
                          xWrapOn, yWrapOn, xSel, ySel);
  assign pxNewFix = spaceFix(pxNew, pxReg, 1'b0, 1'b1, xStart_r, xEnd_r, yStart_r, yEnd_r,
                             xWrapOn, yWrapOn, xSel, ySel);
  assign pyNewFix = spaceFix(pyNew, pyReg, 1'b1, 1'b1, xStart_r, xEnd_r, yStart_r, yEnd_r,
                             xWrapOn, yWrapOn, xSel, ySel);

  // registered addresses and literals, one cycle after the request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      srcAddr <= 16'h0000;
      dstAddr <= 16'h0000;
      pfXAddr <= 16'h0000;
      pfYAddr <= 16'h0000;
      shortLit <= 16'h0000;
      branchLit <= 16'h0000;
      disableLit <= 16'h0000;
      addrValid <= 1'b0;
    end else begin
      addrValid <= opValid | pfValid;
      if (opValid) begin
        srcAddr <= sFix[15:0];
        dstAddr <= dFix[15:0];
        // literal forms: 5-bit, 16-bit signed, 14-bit unsigned
        shortLit <= {11'h000, instrWord[eam_pkg::EAM_SHORT_LIT_W-1:0]};
        branchLit <= instrWord[eam_pkg::EAM_BRANCH_LIT_W-1:0];
        disableLit <= {2'b00, instrWord[eam_pkg::EAM_DISABLE_LIT_W-1:0]};
      end
      if (pfValid) begin
        pfXAddr <= pxFix[15:0];
        pfYAddr <= pyFix[15:0];
      end
    end
  end

  // pointer write-back only for pre/post modes; offset modes leave it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wbValid <= 1'b0;
      wbReg <= 4'h0;
      wbData <= 16'h0000;
      wb2Valid <= 1'b0;
      wb2Reg <= 4'h0;
      wb2Data <= 16'h0000;
    end else if (pfValid) begin
      wbValid <= (pfXMode == 2'h1);
      wbReg <= pxReg;
      wbData <= pxNewFix[15:0];
      wb2Valid <= (pfYMode == 2'h1);
      wb2Reg <= pyReg;
      wb2Data <= pyNewFix[15:0];
    end else if (opValid) begin
      wbValid <= sWb;
      wbReg <= srcPtr;
      wbData <= sModFix[15:0];
      wb2Valid <= dWb;
      wb2Reg <= dstPtr;
      wb2Data <= dModFix[15:0];
    end else begin
      wbValid <= 1'b0;
      wb2Valid <= 1'b0;
    end
  end

  // sticky-free status: last request's wrap events, bit0 X, bit1 Y
  always_ff @(posedge mclk) begin
    if (sys_rst) wrapSeen_r <= 2'b00;
    else if (opValid) wrapSeen_r <= {sFix[16] & srcYSpace, (sFix[16] & !srcYSpace) | dFix[16]};
    else if (pfValid) wrapSeen_r <= {pyFix[16], pxFix[16]};
  end

  // file operand address never exceeds the near region
  AST_FILE_NEAR: assert property (@(posedge mclk) disable iff (sys_rst)
    opValid && srcMode == eam_pkg::EAM_FILE && !srcYSpace |=> srcAddr < 16'h2000)
    else $error("file operand outside near region");

  AST_POST_USES_OLD: assert property (@(posedge mclk) disable iff (sys_rst)
    opValid && srcMode == eam_pkg::EAM_POST && !srcYSpace && !(xWrapOn && srcPtr == xSel)
    |=> srcAddr == $past(sPtrV) && wbData == 16'($past(sPtrV) + $past(modStep)))
    else $error("post-modify address or update wrong");

  AST_PRE_USES_NEW: assert property (@(posedge mclk) disable iff (sys_rst)
    opValid && srcMode == eam_pkg::EAM_PRE && !srcYSpace && !(xWrapOn && srcPtr == xSel)
    |=> srcAddr == wbData && wbValid)
    else $error("pre-modify address differs from update");

  AST_OFS_NO_WB: assert property (@(posedge mclk) disable iff (sys_rst)
    opValid && !pfValid && (srcMode == eam_pkg::EAM_REGOFS || srcMode == eam_pkg::EAM_LITOFS)
    |=> !wbValid)
    else $error("offset mode wrote back pointer");

  AST_Y_EVEN: assert property (@(posedge mclk) disable iff (sys_rst)
    pfValid |=> !pfYAddr[0])
    else $error("Y address odd");

  AST_X_IN_BUF: assert property (@(posedge mclk) disable iff (sys_rst)
    pfValid && xWrapOn && xSel == pxReg && pfXMode == 2'h0 && pxPtr > xEnd_r
    && 16'(pxPtr - xEnd_r) <= 16'(xEnd_r - xStart_r + 16'h0001)
    |=> pfXAddr >= xStart_r && pfXAddr <= xEnd_r)
    else $error("X address not wrapped into buffer");

  AST_SEL_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    pfValid && xSel == eam_pkg::EAM_SEL_OFF && pfXMode != 2'h2 |=> pfXAddr == $past(pxPtr))
    else $error("X prefetch wrapped with select off");

  AST_PF_STEP: assert property (@(posedge mclk) disable iff (sys_rst)
    pfValid && pfXMode == 2'h1 && !(xWrapOn && xSel == pxReg)
    |=> wbValid && wbData == 16'($past(pxPtr) + {13'h0000, $past(pfXStep), 1'b0}))
    else $error("prefetch step wrong");

  // write side under bit-reverse must hand out the plain sum, even inside the buffer
  AST_BITREV_NO_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    opValid && !pfValid && bitRevActive && dstMode == eam_pkg::EAM_LITOFS
    |=> dstAddr == 16'($past(dPtrV) + $past(litOffset)))
    else $error("write side wrapped under bit-reverse");

  // a post-modified Y prefetch hands its pointer back on the second write-back lane
  AST_PF_Y_WB: assert property (@(posedge mclk) disable iff (sys_rst)
    pfValid && pfYMode == 2'h1 |=> wb2Valid && wb2Reg == $past(pyReg))
    else $error("Y prefetch update missing");

  // a Y pointer stepping past the end comes back inside the buffer, still even;
  // only a jump of at most one buffer length is checked, a wider jump is moved back by one length only
  AST_Y_POST_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    opValid && !pfValid && srcYSpace && srcMode == eam_pkg::EAM_POST && yWrapOn
    && srcPtr == ySel && sMod > yEnd_r
    && 16'(sMod - yEnd_r) <= 16'(yEnd_r - yStart_r + 16'h0001)
    |=> wbData >= yStart_r && wbData <= yEnd_r && !wbData[0])
    else $error("Y pointer not wrapped into buffer");
endmodule : eam_generator
`default_nettype wire

// file: design/eam_pkg.sv
package eam_pkg;
  // operand addressing modes presented by the decoder
  typedef enum logic [2:0] {
    EAM_DIRECT,
    EAM_IND,
    EAM_POST,
    EAM_PRE,
    EAM_REGOFS,
    EAM_LITOFS,
    EAM_FILE,
    EAM_ABS
  } eam_mode_e;

  // register map (word offsets on the plain register port)
  localparam logic [2:0] EAM_OFS_MODE_CTRL = 3'h0;
  localparam logic [2:0] EAM_OFS_X_START = 3'h1;
  localparam logic [2:0] EAM_OFS_X_END = 3'h2;
  localparam logic [2:0] EAM_OFS_Y_START = 3'h3;
  localparam logic [2:0] EAM_OFS_Y_END = 3'h4;
  localparam logic [2:0] EAM_OFS_STATUS = 3'h5;

  // mode-control field layout
  localparam int EAM_XSEL_LSB = 0;
  localparam int EAM_YSEL_LSB = 4;
  localparam int EAM_YEN_BIT = 14;
  localparam int EAM_XEN_BIT = 15;
  localparam logic [3:0] EAM_SEL_OFF = 4'hF;
  localparam logic [15:0] EAM_MODE_CTRL_RST = 16'h00FF;
  localparam logic [15:0] EAM_ADDR_RST = 16'h0000;

  // instruction field widths
  localparam int EAM_FILE_W = 13;
  localparam int EAM_SHORT_LIT_W = 5;
  localparam int EAM_BRANCH_LIT_W = 16;
  localparam int EAM_DISABLE_LIT_W = 14;
  localparam int EAM_OFSREG_W = 4;

  // prefetch registers for the dual-operand class
  localparam logic [3:0] EAM_PF_X0 = 4'h8;
  localparam logic [3:0] EAM_PF_X1 = 4'h9;
  localparam logic [3:0] EAM_PF_Y0 = 4'hA;
  localparam logic [3:0] EAM_PF_Y1 = 4'hB;
endpackage : eam_pkg

// file: bench/eam_default_working_register_model.sv
`timescale 1ns/100ps
`default_nettype none
module eam_default_working_register_model (
  input wire logic mclk,
  input wire logic ldEn,
  input wire logic [3:0] ldIdx,
  input wire logic [15:0] ldVal,
  input wire logic wbValid,
  input wire logic [3:0] wbReg,
  input wire logic [15:0] wbData,
  input wire logic wb2Valid,
  input wire logic [3:0] wb2Reg,
  input wire logic [15:0] wb2Data,
  output logic [15:0] regs [16]
);
  // core register file; write-backs land one edge after the answer
  always_ff @(posedge mclk) begin
    if (ldEn) begin
      regs[ldIdx] <= ldVal;
    end
    if (wbValid) begin
      regs[wbReg] <= wbData;
    end
    if (wb2Valid) begin
      regs[wb2Reg] <= wb2Data;
    end
  end
endmodule : eam_default_working_register_model
`default_nettype wire

// file: bench/effective_address_generation_modulo_tb.sv
`timescale 1ns/100ps
`default_nettype none
module effective_address_generation_modulo_tb;
  logic mclk, rst, regWr, regRd, bitRev, opValid, srcY, pfValid, pfXSel, pfYSel, ldEn;
  logic [2:0] regAddr, srcMode, dstMode;
  logic [3:0] srcPtr, dstPtr, ofsReg, ldIdx, wbReg, wb2Reg;
  logic [15:0] regWdata, instr, litOfs, ldVal, regRdata, srcAddr, dstAddr, pfXAddr, pfYAddr;
  logic [15:0] shortLit, branchLit, disableLit, wbData, wb2Data;
  logic signed [15:0] step;
  logic [1:0] pfXMode, pfYMode, pfXStep, pfYStep;
  logic addrValid, wbValid, wb2Valid;
  logic [15:0] wregs [16];
  int n_mismatch, total_checks;

  eam_generator eam_generator_i (.mclk(mclk), .sys_rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .bitRevActive(bitRev), .opValid(opValid), .instrWord(instr), .srcMode(srcMode),
    .srcPtr(srcPtr), .dstMode(dstMode), .dstPtr(dstPtr), .ofsReg(ofsReg),
    .litOffset(litOfs), .modStep(step), .srcYSpace(srcY), .pfValid(pfValid),
    .pfXSel(pfXSel), .pfYSel(pfYSel), .pfXMode(pfXMode), .pfYMode(pfYMode),
    .pfXStep(pfXStep), .pfYStep(pfYStep), .wregs(wregs), .srcAddr(srcAddr),
    .dstAddr(dstAddr), .pfXAddr(pfXAddr), .pfYAddr(pfYAddr), .shortLit(shortLit),
    .branchLit(branchLit), .disableLit(disableLit), .addrValid(addrValid),
    .wbValid(wbValid), .wbReg(wbReg), .wbData(wbData), .wb2Valid(wb2Valid),
    .wb2Reg(wb2Reg), .wb2Data(wb2Data));

  eam_default_working_register_model eam_default_working_register_model_i (.mclk(mclk), .ldEn(ldEn), .ldIdx(ldIdx), .ldVal(ldVal),
    .wbValid(wbValid), .wbReg(wbReg), .wbData(wbData), .wb2Valid(wb2Valid),
    .wb2Reg(wb2Reg), .wb2Data(wb2Data), .regs(wregs));

  // 250 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [15:0] e, input string n);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(n, e, regRdata);
  endtask : rchk

  task automatic ld(input logic [3:0] i, input logic [15:0] v);
    @(posedge mclk);
    ldIdx <= i;
    ldVal <= v;
    ldEn <= 1'b1;
    @(posedge mclk);
    ldEn <= 1'b0;
  endtask : ld

  task automatic op(input logic [2:0] sm, input logic [3:0] sp, input logic [2:0] dm,
                    input logic [3:0] dp, input logic [15:0] st);
    @(posedge mclk);
    srcMode <= sm;
    srcPtr <= sp;
    dstMode <= dm;
    dstPtr <= dp;
    step <= st;
    opValid <= 1'b1;
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
    chk("addrValid", 16'h0001, {15'h0000, addrValid});
  endtask : op

  task automatic pf(input logic xs, input logic [1:0] xm, input logic [1:0] xst,
                    input logic ys, input logic [1:0] ym, input logic [1:0] yst);
    @(posedge mclk);
    pfXSel <= xs;
    pfXMode <= xm;
    pfXStep <= xst;
    pfYSel <= ys;
    pfYMode <= ym;
    pfYStep <= yst;
    pfValid <= 1'b1;
    @(posedge mclk);
    pfValid <= 1'b0;
    #1;
  endtask : pf

  task automatic t_regs();
    rchk(3'h0, eam_pkg::EAM_MODE_CTRL_RST, "modeRst");
    rchk(3'h2, 16'h0000, "xEndRst");
    wr(3'h1, 16'hABCD);
    rchk(3'h1, 16'hABCD, "xStart");
    wr(3'h3, 16'h2001);
    rchk(3'h3, 16'h2000, "yStart");
    wr(3'h6, 16'h1234);
    rchk(3'h6, 16'h0000, "unmapped");
    $display("test regs done");
  endtask : t_regs

  task automatic t_modes();
    ld(4'h3, 16'h0100);
    ld(4'h4, 16'h0020);
    @(posedge mclk);
    instr <= 16'hFFFF;
    litOfs <= 16'hFEDC;
    op(eam_pkg::EAM_FILE, 4'h0, eam_pkg::EAM_ABS, 4'h0, 16'h0000);
    chk("fileAddr", 16'h1FFF, srcAddr);
    chk("absAddr", 16'hFEDC, dstAddr);
    chk("shortLit", 16'h001F, shortLit);
    chk("branchLit", 16'hFFFF, branchLit);
    chk("disableLit", 16'h3FFF, disableLit);
    op(eam_pkg::EAM_IND, 4'h3, eam_pkg::EAM_REGOFS, 4'h3, 16'h0000);
    chk("indAddr", 16'h0100, srcAddr);
    chk("regOfsAddr", 16'h0120, dstAddr);
    chk("noWb", 16'h0000, {15'h0000, wbValid});
    @(posedge mclk);
    litOfs <= 16'h0030;
    op(eam_pkg::EAM_LITOFS, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'h0000);
    chk("litOfsAddr", 16'h0130, srcAddr);
    chk("dstInd", 16'h0020, dstAddr);
    op(eam_pkg::EAM_POST, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'h0002);
    chk("postAddr", 16'h0100, srcAddr);
    chk("postWb", 16'h0102, wbData);
    op(eam_pkg::EAM_PRE, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'hFFFC);
    chk("preAddr", 16'h00FE, srcAddr);
    chk("preWb", 16'h00FE, wbData);
    $display("test modes done");
  endtask : t_modes

  task automatic t_pf();
    logic [15:0] e;
    ld(4'h8, 16'h0800);
    ld(4'hB, 16'h0B00);
    ld(4'hC, 16'h0010);
    e = 16'h0800;
    // each step code moves the pointer by twice its value
    for (int k = 1; k < 4; k++) begin
      pf(1'b0, 2'h1, k[1:0], 1'b1, 2'h2, 2'h0);
      chk("pfX", e, pfXAddr);
      chk("pfYIdx", 16'h0B10, pfYAddr);
      e = e + 16'(2 * k);
      chk("pfXWb", 16'h0001, {15'h0000, (wbValid && wbReg === 4'h8 && wbData === e)
        || (wb2Valid && wb2Reg === 4'h8 && wb2Data === e)});
    end
    ld(4'hA, 16'h0A00);
    pf(1'b0, 2'h0, 2'h0, 1'b0, 2'h1, 2'h3);
    chk("pfXInd", 16'h080C, pfXAddr);
    chk("pfY", 16'h0A00, pfYAddr);
    chk("pfYWb", 16'h0A06, wb2Data);
    chk("pfYWbReg", 16'h000A, {12'h000, wb2Reg});
    chk("pfYWbOn", 16'h0001, {15'h0000, wb2Valid});
    chk("pfXNoWb", 16'h0000, {15'h0000, wbValid});
    $display("test prefetch done");
  endtask : t_pf

  task automatic t_xwrap();
    wr(3'h1, 16'h1000);
    wr(3'h2, 16'h100F);
    wr(3'h0, 16'h80F3);
    ld(4'h3, 16'h100E);
    ld(4'h4, 16'h0004);
    op(eam_pkg::EAM_POST, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'h0004);
    chk("xPostAddr", 16'h100E, srcAddr);
    chk("xPostWb", 16'h1002, wbData);
    op(eam_pkg::EAM_PRE, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'hFFFC);
    chk("xPreAddr", 16'h100E, srcAddr);
    // status flags a wrapped access address, so look after the pre-modify
    rchk(3'h5, 16'h0001, "xStatus");
    @(posedge mclk);
    litOfs <= 16'h0004;
    bitRev <= 1'b1;
    op(eam_pkg::EAM_REGOFS, 4'h3, eam_pkg::EAM_LITOFS, 4'h3, 16'h0000);
    chk("xOfsAddr", 16'h1002, srcAddr);
    chk("xBitRevDst", 16'h1012, dstAddr);
    chk("xOfsNoWb", 16'h0000, {15'h0000, wbValid});
    @(posedge mclk);
    bitRev <= 1'b0;
    wr(3'h0, 16'h800F);
    op(eam_pkg::EAM_POST, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'h0004);
    chk("xSelOff", 16'h1012, wbData);
    wr(3'h0, 16'h00F3);
    op(eam_pkg::EAM_PRE, 4'h3, eam_pkg::EAM_IND, 4'h4, 16'h0004);
    chk("xEnOff", 16'h1016, srcAddr);
    wr(3'h0, 16'h80F8);
    ld(4'h8, 16'h1014);
    pf(1'b0, 2'h0, 2'h0, 1'b0, 2'h0, 2'h0);
    chk("pfXWrap", 16'h1004, pfXAddr);
    $display("test x wrap done");
  endtask : t_xwrap

  task automatic t_ywrap();
    wr(3'h3, 16'h2000);
    wr(3'h4, 16'h2006);
    rchk(3'h4, 16'h2007, "yEnd");
    wr(3'h0, 16'h405F);
    ld(4'h5, 16'h2006);
    @(posedge mclk);
    srcY <= 1'b1;
    op(eam_pkg::EAM_POST, 4'h5, eam_pkg::EAM_IND, 4'h4, 16'h0002);
    chk("yPostAddr", 16'h2006, srcAddr);
    chk("yPostWb", 16'h2000, wbData);
    ld(4'h5, 16'h2003);
    op(eam_pkg::EAM_IND, 4'h5, eam_pkg::EAM_IND, 4'h4, 16'h0000);
    chk("yLsb", 16'h2002, srcAddr);
    wr(3'h0, 16'h005F);
    ld(4'h5, 16'h2006);
    op(eam_pkg::EAM_POST, 4'h5, eam_pkg::EAM_IND, 4'h4, 16'h0002);
    chk("yEnOff", 16'h2008, wbData);
    $display("test y wrap done");
  endtask : t_ywrap

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    {rst, regWr, regRd, bitRev, opValid, srcY, pfValid, pfXSel, pfYSel, ldEn} = 10'h200;
    // offset register 4 for the register-offset scenarios; indexed prefetch uses register 12
    {regAddr, srcMode, dstMode, srcPtr, dstPtr, ofsReg, ldIdx} = 25'h0000040;
    {regWdata, instr, litOfs, ldVal, step} = 80'h0;
    {pfXMode, pfYMode, pfXStep, pfYStep} = 8'h00;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_pf();
    t_xwrap();
    t_ywrap();
    stop_test();
  end
endmodule : effective_address_generation_modulo_tb
`default_nettype wire
